//--- common/swbw_map.vh
// Purpose: Constants for the single-wire bit and byte write engine.
// Assumes: sys_clk at 50 MHz; included by bare name.
// Notes:   Times are in ns; cycle counts derive from them.
`ifndef SWBW_MAP_VH
`define SWBW_MAP_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define SWBW_CLK_NS 20
// Read sample point after slot start, per speed
`define SWBW_SAMPLE_STD_NS 15000
`define SWBW_SAMPLE_OD_NS 2000
`define SWBW_SAMPLE_STD_CYC ((`SWBW_SAMPLE_STD_NS + `SWBW_CLK_NS - 1) / `SWBW_CLK_NS)
`define SWBW_SAMPLE_OD_CYC ((`SWBW_SAMPLE_OD_NS + `SWBW_CLK_NS - 1) / `SWBW_CLK_NS)
// Longest delay from parameter acknowledge edge to line activity
`define SWBW_START_LAT_NS 1090
`define SWBW_START_LAT_CYC (`SWBW_START_LAT_NS / `SWBW_CLK_NS)

// ----------------------------------------------------------------
// Commands and parameter fields
// ----------------------------------------------------------------
`define SWBW_CMD_SINGLE_BIT 8'h87
`define SWBW_CMD_WRITE_BYTE 8'hA5
`define SWBW_PARAM_V_BIT 7
`define SWBW_BYTE_BITS 4'h8

// ----------------------------------------------------------------
// Line status byte returned on a serial read
// ----------------------------------------------------------------
`define SWBW_STAT_BUSY_BIT 0
`define SWBW_STAT_RESULT_BIT 5
`define SWBW_STAT_DIR_BIT 7
`define SWBW_STAT_RESET 8'h00

`endif

//--- core/swbw_slot.v
// Purpose: Generates one line time slot and samples the line in it.
// Assumes: Low times and recovery are given in sys_clk cycles, >= 1.
// Notes:   Slot period is write-zero low time plus recovery time.
`timescale 1ns/100ps
`include "swbw_map.vh"

module swbw_slot (
   input wire sys_clk,
   input wire reset,
   input wire start,
   input wire bitVal,
   input wire speedSelect,
   input wire [11:0] writeZeroLow,
   input wire [11:0] writeOneLow,
   input wire [11:0] recovery,
   input wire lineLevel,
   output reg lineLow_r,
   output reg sampled_r,
   output reg sampleStrobe_r,
   output reg done_r
);

   reg busy_r;
   reg [13:0] count_r;
   reg [13:0] lowLen_r;
   reg [13:0] slotLen_r;
   reg [13:0] sampleAt_r;

   // Sample points as wide constants, cut to the counter width on use
   localparam [31:0] SAMPLE_OD_W = `SWBW_SAMPLE_OD_CYC;
   localparam [31:0] SAMPLE_STD_W = `SWBW_SAMPLE_STD_CYC;

   // ----------------------------------------------------------------
   // Slot sequencer; settings latched at start so a mid-slot change
   // cannot stretch or cut the waveform
   // ----------------------------------------------------------------
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         busy_r <= 1'b0;
         count_r <= 14'h0000;
         lowLen_r <= 14'h0000;
         slotLen_r <= 14'h0000;
         sampleAt_r <= 14'h0000;
         lineLow_r <= 1'b0;
         sampled_r <= 1'b0;
         sampleStrobe_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         sampleStrobe_r <= 1'b0;
         done_r <= 1'b0;
         if (start && !busy_r) begin
            busy_r <= 1'b1;
            count_r <= 14'h0000;
            lineLow_r <= 1'b1;
            lowLen_r <= {2'b00, (bitVal ? writeOneLow : writeZeroLow)};
            slotLen_r <= {2'b00, writeZeroLow} + {2'b00, recovery};
            sampleAt_r <= speedSelect ? SAMPLE_OD_W[13:0] : SAMPLE_STD_W[13:0];
         end else if (busy_r) begin
            count_r <= count_r + 14'h0001;
            if (count_r == lowLen_r) begin
               lineLow_r <= 1'b0;
            end
            if (count_r == sampleAt_r) begin
               sampled_r <= lineLevel; // [R3]
               sampleStrobe_r <= 1'b1;
            end
            if (count_r == slotLen_r) begin
               busy_r <= 1'b0;
               lineLow_r <= 1'b0;
               done_r <= 1'b1;
            end
         end
      end
   end

endmodule // swbw_slot

//--- core/swbw_sync.v
// Purpose: Two-stage synchroniser for one asynchronous level.
// Assumes: Input comes from a pin or another clock domain.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/100ps

module swbw_sync (
   input wire sys_clk,
   input wire reset,
   input wire asyncIn,
   output reg syncOut_r
);

   reg meta_r;

   // ----------------------------------------------------------------
   // Double flop; stage one feeds stage two only
   // ----------------------------------------------------------------
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         meta_r <= 1'b1;
         syncOut_r <= 1'b1;
      end else begin
         meta_r <= asyncIn;
         syncOut_r <= meta_r;
      end
   end

endmodule // swbw_sync

//--- core/swbw_top.v
// Purpose: Serial-command front end running single-slot and byte-write
//          operations on a single-wire line.
// Assumes: SCL, SDA and the line level are asynchronous pins; config
//          inputs come from logic on sys_clk.
// Notes:   SDA and the line are open drain: the enable pulls them low.
`timescale 1ns/100ps
`include "swbw_map.vh"

// Function
// [R1] Command 87h plus one parameter byte yields exactly one time slot.
// [R2] Parameter bit 7 picks a write-zero slot when 0 and a write-one/read slot when 1.
// [R3] The line level at the read sample point is stored in the single-bit result flag.
// [R4] A line command code arriving while the line is busy is not acknowledged and ignored.
// [R5] The host waits for line activity to end before issuing another line command.
// [R6] A single-slot operation holds busy for one slot period and may update the direction flag.
// [R7] Line activity starts within 1.09 us of the parameter acknowledge clock rise.
// [R8] After a single-slot command the read pointer sits on the line status register.
// [R9] Both commands use the current speed, pullup selections and slot timing settings.
// [R10] Command A5h plus one parameter byte carries eight data bits for the line.
// [R11] The byte is sent as eight slots, each typed by its data bit.
// [R12] The slot for data bit 0 goes out first.
// [R13] No line activity begins before the whole parameter byte is in.
// [R14] Busy holds for eight slot periods, then clears; the pointer stays on status.
// [R15] Command and parameter travel in one serial write transaction.
module swbw_top #(
   parameter [6:0] DEV_ADDR = 7'h3C // Arbitrary bus address
) (
   input wire sys_clk,
   input wire reset,
   input wire sclIn,
   input wire sdaIn,
   output reg sdaOut_r,
   output reg sdaOe_r,
   input wire lineIn,
   output reg lineOut_r,
   output wire lineOe,
   input wire speedSelect,
   input wire activePullupSelect,
   input wire strongPullupSelect,
   input wire [11:0] writeZeroLowTime,
   input wire [11:0] writeOneLowTime,
   input wire [11:0] recoveryTime,
   input wire [1:0] weakPullupSetting,
   output reg activePullupEn_r,
   output reg strongPullupEn_r,
   output reg [1:0] weakPullupLevel_r,
   output reg lineBusyFlag_r,
   output reg singleBitResult_r,
   output reg branchDirection_r,
   output reg readPtrStatus_r
);

   // ----------------------------------------------------------------
   // Serial receiver states
   // ----------------------------------------------------------------
   localparam [2:0] I_IDLE = 3'h0;
   localparam [2:0] I_BITS = 3'h1;
   localparam [2:0] I_ACK = 3'h2;
   localparam [2:0] I_ACKH = 3'h3;
   localparam [2:0] I_TX = 3'h4;
   localparam [2:0] I_RACK = 3'h5;
   localparam [2:0] I_IGNORE = 3'h6;

   wire sclS;
   wire sdaS;
   wire lineS;
   reg sclPrev_r;
   reg sdaPrev_r;
   reg [2:0] iState_r;
   reg [7:0] shift_r;
   reg [3:0] bitCnt_r;
   reg [1:0] byteIdx_r;
   reg readMode_r;
   reg ackPend_r;
   reg [7:0] cmd_r;
   reg [7:0] txShift_r;
   reg launch_r;
   reg [7:0] param_r;

   // Line operation state
   reg isSingle_r;
   reg [7:0] data_r;
   reg [3:0] bitsLeft_r;
   reg slotStart_r;
   wire slotLow;
   wire slotSampled;
   wire slotStrobe;
   wire slotDone;

   wire sclRise = sclS & ~sclPrev_r;
   wire sclFall = ~sclS & sclPrev_r;
   wire startCond = sclS & sclPrev_r & sdaPrev_r & ~sdaS;
   wire stopCond = sclS & sclPrev_r & ~sdaPrev_r & sdaS;
   wire [7:0] rxByte = {shift_r[6:0], sdaS};
   wire cmdKnown = (rxByte == `SWBW_CMD_SINGLE_BIT) || (rxByte == `SWBW_CMD_WRITE_BYTE);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   swbw_sync u_sclSync (
      .sys_clk(sys_clk),
      .reset(reset),
      .asyncIn(sclIn),
      .syncOut_r(sclS)
   );

   swbw_sync u_sdaSync (
      .sys_clk(sys_clk),
      .reset(reset),
      .asyncIn(sdaIn),
      .syncOut_r(sdaS)
   );

   swbw_sync u_lineSync (
      .sys_clk(sys_clk),
      .reset(reset),
      .asyncIn(lineIn),
      .syncOut_r(lineS)
   );

   // ----------------------------------------------------------------
   // Serial slave: address, command, parameter, status read
   // ----------------------------------------------------------------
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
         iState_r <= I_IDLE;
         shift_r <= 8'h00;
         bitCnt_r <= 4'h0;
         byteIdx_r <= 2'h0;
         readMode_r <= 1'b0;
         ackPend_r <= 1'b0;
         cmd_r <= 8'h00;
         txShift_r <= 8'h00;
         launch_r <= 1'b0;
         param_r <= 8'h00;
         sdaOe_r <= 1'b0;
         sdaOut_r <= 1'b0;
      end else begin
         sclPrev_r <= sclS;
         sdaPrev_r <= sdaS;
         launch_r <= 1'b0;
         sdaOut_r <= 1'b0;
         if (startCond) begin
            // Repeated start restarts address decode
            iState_r <= I_BITS;
            bitCnt_r <= 4'h0;
            byteIdx_r <= 2'h0;
            sdaOe_r <= 1'b0;
         end else if (stopCond) begin
            iState_r <= I_IDLE;
            sdaOe_r <= 1'b0;
         end else begin
            case (iState_r)
               I_BITS: begin
                  if (sclRise) begin
                     shift_r <= rxByte;
                     bitCnt_r <= bitCnt_r + 4'h1;
                     if (bitCnt_r == 4'h7) begin
                        iState_r <= I_ACK;
                        bitCnt_r <= 4'h0;
                        case (byteIdx_r)
                           2'h0: begin
                              ackPend_r <= (rxByte[7:1] == DEV_ADDR);
                              readMode_r <= rxByte[0];
                           end
                           2'h1: begin
                              cmd_r <= rxByte;
                              ackPend_r <= cmdKnown & ~lineBusyFlag_r; // [R4]
                           end
                           2'h2: begin
                              param_r <= rxByte;
                              ackPend_r <= 1'b1;
                           end
                           default: begin
                              ackPend_r <= 1'b0; // [R15]
                           end
                        endcase
                     end
                  end
               end
               I_ACK: begin
                  if (sclFall) begin
                     sdaOe_r <= ackPend_r;
                     iState_r <= I_ACKH;
                  end
               end
               I_ACKH: begin
                  // Launch on the acknowledge clock rise of the full parameter
                  if (sclRise && ackPend_r && (byteIdx_r == 2'h2)) begin
                     launch_r <= 1'b1; // [R7] [R13]
                  end
                  if (sclFall) begin
                     if (!ackPend_r) begin
                        sdaOe_r <= 1'b0;
                        iState_r <= I_IGNORE;
                     end else if (readMode_r) begin
                        txShift_r <= {branchDirection_r, 1'b0, singleBitResult_r, 4'h0,
                                      lineBusyFlag_r};
                        sdaOe_r <= ~branchDirection_r;
                        bitCnt_r <= 4'h0;
                        iState_r <= I_TX;
                     end else begin
                        sdaOe_r <= 1'b0;
                        byteIdx_r <= (byteIdx_r == 2'h3) ? 2'h3 : byteIdx_r + 2'h1;
                        iState_r <= I_BITS;
                     end
                  end
               end
               I_TX: begin
                  if (sclFall) begin
                     bitCnt_r <= bitCnt_r + 4'h1;
                     txShift_r <= {txShift_r[6:0], 1'b0};
                     if (bitCnt_r == 4'h7) begin
                        sdaOe_r <= 1'b0;
                        iState_r <= I_RACK;
                     end else begin
                        sdaOe_r <= ~txShift_r[6];
                     end
                  end
               end
               I_RACK: begin
                  // Host acknowledge keeps the status stream going
                  if (sclRise) begin
                     ackPend_r <= ~sdaS;
                  end
                  if (sclFall) begin
                     if (ackPend_r) begin
                        txShift_r <= {branchDirection_r, 1'b0, singleBitResult_r, 4'h0,
                                      lineBusyFlag_r};
                        sdaOe_r <= ~branchDirection_r;
                        bitCnt_r <= 4'h0;
                        iState_r <= I_TX;
                     end else begin
                        iState_r <= I_IGNORE;
                     end
                  end
               end
               I_IDLE: begin
                  sdaOe_r <= 1'b0;
               end
               I_IGNORE: begin
                  sdaOe_r <= 1'b0;
               end
               default: begin
                  sdaOe_r <= 1'b0;
                  iState_r <= I_IDLE;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Operation sequencer: one slot or eight, LSB first
   // ----------------------------------------------------------------
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         isSingle_r <= 1'b0;
         data_r <= 8'h00;
         bitsLeft_r <= 4'h0;
         slotStart_r <= 1'b0;
         lineBusyFlag_r <= 1'b0;
         singleBitResult_r <= 1'b0;
         branchDirection_r <= 1'b0;
         readPtrStatus_r <= 1'b0;
         strongPullupEn_r <= 1'b0;
      end else begin
         slotStart_r <= 1'b0;
         if (launch_r && !lineBusyFlag_r) begin
            lineBusyFlag_r <= 1'b1; // [R6] [R14]
            readPtrStatus_r <= 1'b1; // [R8] [R14]
            strongPullupEn_r <= 1'b0;
            slotStart_r <= 1'b1;
            if (cmd_r == `SWBW_CMD_SINGLE_BIT) begin
               isSingle_r <= 1'b1;
               data_r <= {7'h00, param_r[`SWBW_PARAM_V_BIT]}; // [R2]
               bitsLeft_r <= 4'h1; // [R1]
            end else begin
               isSingle_r <= 1'b0;
               data_r <= param_r; // [R10]
               bitsLeft_r <= `SWBW_BYTE_BITS; // [R11]
            end
         end else if (slotDone) begin
            data_r <= {1'b0, data_r[7:1]}; // [R12]
            bitsLeft_r <= bitsLeft_r - 4'h1;
            if (bitsLeft_r == 4'h1) begin
               lineBusyFlag_r <= 1'b0; // [R6] [R14]
               strongPullupEn_r <= strongPullupSelect; // [R9]
            end else begin
               slotStart_r <= 1'b1; // [R11]
            end
         end
         if (slotStrobe && isSingle_r) begin
            singleBitResult_r <= slotSampled; // [R3]
            branchDirection_r <= slotSampled; // [R6]
         end
      end
   end

   // ----------------------------------------------------------------
   // Slot engine; timing taken live from configuration inputs
   // ----------------------------------------------------------------
   swbw_slot u_slot (
      .sys_clk(sys_clk),
      .reset(reset),
      .start(slotStart_r),
      .bitVal(data_r[0]),
      .speedSelect(speedSelect),
      .writeZeroLow(writeZeroLowTime),
      .writeOneLow(writeOneLowTime),
      .recovery(recoveryTime),
      .lineLevel(lineS),
      .lineLow_r(slotLow),
      .sampled_r(slotSampled),
      .sampleStrobe_r(slotStrobe),
      .done_r(slotDone)
   );

   // Slot low drive is itself a flip-flop output
   assign lineOe = slotLow;

   // ----------------------------------------------------------------
   // Pullup controls; active pullup follows the line release one cycle late, so it is also on for the first cycle of each low pulse
   // ----------------------------------------------------------------
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         activePullupEn_r <= 1'b0;
         weakPullupLevel_r <= 2'b00;
         lineOut_r <= 1'b0;
      end else begin
         activePullupEn_r <= activePullupSelect & lineBusyFlag_r & ~slotLow; // [R9]
         weakPullupLevel_r <= weakPullupSetting; // [R9]
         lineOut_r <= 1'b0;
      end
   end

endmodule // swbw_top

//--- testbench/swbw_host_model.sv
// Purpose: Serial host that issues line commands to the engine.
// Assumes: SDA is open drain and resolved by the bench; no clock stretching.
// Notes:   SCL period 160 ns; SCL idles high, still between transfers.
`timescale 1ns/100ps

module swbw_host_model #(
   parameter [6:0] ADDR = 7'h3C
) (
   input wire sys_clk,
   output logic scl,
   output logic sdaLow,
   input wire sda
);
   time ackRise = 0;
   time lastRise = 0;

   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end

   // One bit: data set mid-low, sampled mid-high, so it stays put while SCL is high
   task automatic xbit(input bit b, output bit seen);
      scl = 1'b0;
      #40 sdaLow = !b;
      #40 scl = 1'b1;
      lastRise = $time;
      #40 seen = sda;
      #40;
   endtask

   // MSB first, then release SDA for the acknowledge bit
   task automatic sendByte(input [7:0] b, output bit ack);
      bit s;
      for (int i = 7; i >= 0; i--) xbit(b[i], s);
      xbit(1'b1, s);
      ack = !s;
   endtask

   // Address, code and parameter in one transaction; stops early on a refusal
   task automatic writeCmd(input [7:0] cmd, input [7:0] par, output bit aAdr,
                           output bit aCmd, output bit aPar);
      aCmd = 1'b0;
      aPar = 1'b0;
      @(posedge sys_clk) #1 sdaLow = 1'b1;
      #80 sendByte({ADDR, 1'b0}, aAdr);
      if (aAdr) sendByte(cmd, aCmd);
      if (aCmd) begin
         sendByte(par, aPar);
         ackRise = lastRise;
      end
      stopBus;
   endtask

   // Stop: SDA rises while SCL is high, then bus free time
   task automatic stopBus;
      scl = 1'b0;
      #40 sdaLow = 1'b1;
      #40 scl = 1'b1;
      #40 sdaLow = 1'b0;
      #80;
   endtask

   // Status read: one byte in, then no acknowledge so the device lets go
   task automatic readStatus(output [7:0] st);
      bit s;
      @(posedge sys_clk) #1 sdaLow = 1'b1;
      #80 sendByte({ADDR, 1'b1}, s);
      for (int i = 7; i >= 0; i--) xbit(1'b1, st[i]);
      xbit(1'b1, s);
      stopBus;
   endtask
endmodule // swbw_host_model

//--- testbench/swbw_top_properties.sv
// Purpose: Port-level checker for the bit and byte write engine.
// Assumes: One clock domain, sys_clk, reset async active high.
// Notes:   Bound into every instance of the top module.
`timescale 1ns/100ps

module swbw_chk (
   input wire sys_clk,
   input wire reset,
   input wire lineOe,
   input wire [11:0] writeZeroLowTime,
   input wire [11:0] writeOneLowTime,
   input wire activePullupSelect,
   input wire strongPullupSelect,
   input wire activePullupEn_r,
   input wire strongPullupEn_r,
   input wire lineBusyFlag_r,
   input wire singleBitResult_r,
   input wire readPtrStatus_r
);
   reg [12:0] oeCnt;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);

   // Length of the current low pulse, so its width can be tied to the settings
   always @(posedge sys_clk or posedge reset) begin
      if (reset)
         oeCnt <= 13'h0000;
      else if (lineOe)
         oeCnt <= oeCnt + 13'h0001;
      else
         oeCnt <= 13'h0000;
   end

   // ------------------------------------------------------------
   // Line timing
   // ------------------------------------------------------------
   AST_LAUNCH_OE: assert property ($rose(lineBusyFlag_r) |-> ##1 lineOe)
      else $error("line not driven one cycle after busy rose");
   AST_LOW_WIDTH: assert property ($fell(lineOe) |->
      (oeCnt == {1'b0, writeZeroLowTime} + 13'h0001) ||
      (oeCnt == {1'b0, writeOneLowTime} + 13'h0001))
      else $error("low pulse width matches neither low time");
   AST_OE_IN_BUSY: assert property (lineOe |-> lineBusyFlag_r)
      else $error("line driven while not busy");
   AST_BUSY_MIN: assert property ($rose(lineBusyFlag_r) |-> lineBusyFlag_r[*3])
      else $error("busy shorter than a slot");

   // ------------------------------------------------------------
   // Status and pullups
   // ------------------------------------------------------------
   AST_PTR: assert property ($rose(lineBusyFlag_r) |-> readPtrStatus_r)
      else $error("pointer not on status at launch");
   AST_RESULT_IN_BUSY: assert property ($changed(singleBitResult_r) |->
      $past(lineBusyFlag_r))
      else $error("result changed outside an operation");
   AST_ACTIVE_PU: assert property (activePullupEn_r |->
      $past(activePullupSelect) && $past(lineBusyFlag_r))
      else $error("active pullup without selection or busy");
   AST_STRONG_PU: assert property ($rose(strongPullupEn_r) |->
      $past(strongPullupSelect) && !lineBusyFlag_r)
      else $error("strong pullup without selection or during busy");
endmodule // swbw_chk

bind swbw_top swbw_chk u_chk (.sys_clk, .reset, .lineOe, .writeZeroLowTime,
   .writeOneLowTime, .activePullupSelect, .strongPullupSelect, .activePullupEn_r,
   .strongPullupEn_r, .lineBusyFlag_r, .singleBitResult_r, .readPtrStatus_r);

//--- testbench/tb_top.sv
// Purpose: Self-checking bench for single-slot and byte-write commands.
// Assumes: Slaves on the line are modelled here as a pull-down window.
// Notes:   Random parameters from a fixed seed, plus corner bytes.
`timescale 1ns/100ps
`include "swbw_map.vh"

module tb_top;
   logic sys_clk, reset, speedSelect, activePullupSelect, strongPullupSelect;
   logic [11:0] writeZeroLowTime, writeOneLowTime, recoveryTime;
   logic [1:0] weakPullupSetting;
   wire sclIn, sdaIn, sdaOut_r, sdaOe_r, lineIn, lineOut_r, lineOe, hostSdaLow;
   wire activePullupEn_r, strongPullupEn_r, lineBusyFlag_r, singleBitResult_r;
   wire branchDirection_r, readPtrStatus_r;
   wire [1:0] weakPullupLevel_r;
   int failures = 0, total_checks = 0, seed = 96398;
   int busyCnt = 0, oeRises = 0, width = 0, slaveCnt = 0;
   int widths[$];
   logic oePrev = 1'b0, slaveBit = 1'b1;
   bit a0, a1, a2;
   time firstRise = 0;

   // Open-drain wires: anyone pulling low wins, idle level is high
   assign sdaIn = ~(hostSdaLow | sdaOe_r);
   assign lineIn = ~(lineOe | (slaveCnt != 0));

   swbw_top dut (.sys_clk, .reset, .sclIn, .sdaIn, .sdaOut_r, .sdaOe_r, .lineIn,
      .lineOut_r, .lineOe, .speedSelect, .activePullupSelect, .strongPullupSelect,
      .writeZeroLowTime, .writeOneLowTime, .recoveryTime, .weakPullupSetting,
      .activePullupEn_r, .strongPullupEn_r, .weakPullupLevel_r, .lineBusyFlag_r,
      .singleBitResult_r, .branchDirection_r, .readPtrStatus_r);
   swbw_host_model host (.sys_clk, .scl(sclIn), .sdaLow(hostSdaLow), .sda(sdaIn));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // Slot monitor; a slave answering 0 holds the line past the sample point
   always @(posedge sys_clk) begin
      oePrev <= lineOe;
      if (lineBusyFlag_r) busyCnt <= busyCnt + 1;
      if (slaveCnt != 0) slaveCnt <= slaveCnt - 1;
      if (lineOe && !oePrev) begin
         oeRises <= oeRises + 1;
         if (oeRises == 0) firstRise <= $time;
         width <= 1;
         if (!slaveBit) slaveCnt <= speedSelect ? 110 : 760;
      end else if (lineOe) width <= width + 1;
      if (!lineOe && oePrev) widths.push_back(width);
   end

   task automatic chk(input [31:0] got, input [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_of_test;
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Expected low pulse of slot i: byte bits go out LSB first
   function automatic [31:0] expW(input [7:0] cmd, input [7:0] par, input int i);
      logic b;
      b = (cmd == `SWBW_CMD_WRITE_BYTE) ? par[i] : par[`SWBW_PARAM_V_BIT];
      expW = b ? writeOneLowTime + 32'h1 : writeZeroLowTime + 32'h1;
   endfunction

   // One command, optionally with a second one fired while the line is busy
   task automatic runOp(input [7:0] cmd, input [7:0] par, input bit collide, input bit sb);
      int n, s, i;
      bit r;
      logic [7:0] st;
      @(posedge sys_clk) #1;
      activePullupSelect = $random(seed);
      strongPullupSelect = $random(seed);
      weakPullupSetting = $random(seed);
      slaveBit = sb;
      busyCnt = 0;
      oeRises = 0;
      widths.delete();
      n = (cmd == `SWBW_CMD_WRITE_BYTE) ? 8 : 1;
      s = writeZeroLowTime + recoveryTime + 1;
      host.writeCmd(cmd, par, a0, a1, a2);
      chk({a0, a1, a2}, 3'h7);
      if (collide) begin
         host.writeCmd(`SWBW_CMD_SINGLE_BIT, 8'h80, a0, a1, a2);
         chk({a0, a1}, 2'h2);
      end
      i = 0;
      while ((busyCnt == 0 || lineBusyFlag_r) && i < 20000) begin
         @(posedge sys_clk) #1;
         i++;
      end
      chk(i < 20000, 1);
      chk(oeRises, n);
      for (i = 0; i < n; i++) chk(widths[i], expW(cmd, par, i));
      chk(firstRise > host.ackRise && firstRise - host.ackRise <= 1090, 1);
      chk(busyCnt >= n * s && busyCnt <= n * (s + 3) + 3, 1);
      chk(readPtrStatus_r, 1);
      chk({strongPullupEn_r, weakPullupLevel_r}, {strongPullupSelect, weakPullupSetting});
      chk({sdaOut_r, lineOut_r}, 2'h0);
      if (n == 1) begin
         r = par[7] & sb;
         chk({singleBitResult_r, branchDirection_r}, {r, r});
         host.readStatus(st);
         chk(st, (8'(r) << `SWBW_STAT_DIR_BIT) | (8'(r) << `SWBW_STAT_RESULT_BIT));
      end
   endtask

   initial begin
      reset = 1'b1;
      speedSelect = 1'b1;
      activePullupSelect = 1'b0;
      strongPullupSelect = 1'b0;
      writeZeroLowTime = 12'h078;
      writeOneLowTime = 12'h00A;
      recoveryTime = 12'h014;
      weakPullupSetting = 2'h0;
      repeat (6) @(posedge sys_clk);
      #1 reset = 1'b0;
      repeat (4) @(posedge sys_clk);
      #1 chk(readPtrStatus_r, 0);
      // Both slot types with both slave answers
      for (int k = 0; k < 4; k++) runOp(`SWBW_CMD_SINGLE_BIT, {k[0], 7'($random(seed))}, 0, k[1]);
      runOp(`SWBW_CMD_WRITE_BYTE, 8'h01, 0, 1'b1);
      runOp(`SWBW_CMD_WRITE_BYTE, 8'h80, 0, 1'b0);
      for (int k = 0; k < 3; k++) runOp(`SWBW_CMD_WRITE_BYTE, 8'($random(seed)), 0, 1'b1);
      runOp(`SWBW_CMD_WRITE_BYTE, 8'($random(seed)), 1, 1'b1);
      // Unknown code is refused and starts nothing
      oeRises = 0;
      host.writeCmd(8'h96, 8'h80, a0, a1, a2);
      chk({a0, a1}, 2'h2);
      repeat (100) @(posedge sys_clk);
      #1 chk(oeRises, 0);
      // Standard speed moves the sample point
      speedSelect = 1'b0;
      writeZeroLowTime = 12'h30C;
      recoveryTime = 12'h028;
      runOp(`SWBW_CMD_SINGLE_BIT, 8'h80, 0, 1'b0);
      runOp(`SWBW_CMD_SINGLE_BIT, 8'hFF, 0, 1'b1);
      runOp(`SWBW_CMD_SINGLE_BIT, 8'h7F, 0, 1'b1);
      end_of_test;
   end

   // Watchdog: whole sequence needs well under a millisecond
   initial begin
      #1500000;
      failures++;
      end_of_test;
   end
endmodule // tb_top
